// >>> common/tach_xfer_if.sv
// handshake carrier for the measured fan count between clock domains
`timescale 1ns/10ps
`default_nettype none
interface tach_xfer_if;
    logic [7:0] count;    // measured count, stable while req differs from ack
    logic       req;      // toggles when a new count is offered
    logic       ack;      // follows req once the count is taken
    logic [1:0] ppr_code; // pulses-per-revolution code, quasi-static level
    modport tach_side (output count, output req, input ack, input ppr_code);
    modport sys_side  (input count, input req, output ack);
endinterface
`default_nettype wire

// >>> common/thermal_fan_pkg.sv
// constants shared by the thermal and fan register bank
`default_nettype none
package thermal_fan_pkg;
    // command codes
    localparam logic [7:0] CMD_REMOTE2_HIGH   = 8'h00;
    localparam logic [7:0] CMD_REMOTE1_HIGH   = 8'h01;
    localparam logic [7:0] CMD_FAULT_FLAGS    = 8'h02;
    localparam logic [7:0] CMD_CONFIG_RD      = 8'h03;
    localparam logic [7:0] CMD_RATE_RD        = 8'h04;
    localparam logic [7:0] CMD_REMOTE3_HIGH   = 8'h05;
    localparam logic [7:0] CMD_REMOTE1_FRAC   = 8'h06;
    localparam logic [7:0] CMD_REMOTE23_FRAC  = 8'h07;
    localparam logic [7:0] CMD_SHUTDOWN       = 8'h08;
    localparam logic [7:0] CMD_CONFIG_WR      = 8'h09;
    localparam logic [7:0] CMD_RATE_WR        = 8'h0a;
    localparam logic [7:0] CMD_SINGLE_CONVERSION_TRIGGER        = 8'h0f;
    localparam logic [7:0] CMD_FAN_TARGET     = 8'h10;
    localparam logic [7:0] CMD_FAN_MEASURED   = 8'h11;
    localparam logic [7:0] CMD_FAN_DRIVE      = 8'h12;
    localparam logic [7:0] CMD_OFFSET1        = 8'h16;
    localparam logic [7:0] CMD_OFFSET2        = 8'h17;
    localparam logic [7:0] CMD_OFFSET3        = 8'h18;
    localparam logic [7:0] CMD_TACH_PPR       = 8'h19;
    localparam logic [7:0] CMD_UNLOCK         = 8'h20;
    // configuration field positions
    localparam int CFG_ALERT_MASK_BIT = 7;
    localparam int CFG_FAIL_DET_BIT   = 5;
    localparam int CFG_FCON_DET_BIT   = 4;
    localparam int CFG_LOOP_BIT       = 1;
    localparam int UNLOCK_BIT         = 0;
    // status field positions
    localparam int STAT_BUSY_BIT  = 7;
    localparam int STAT_FAIL_BIT  = 6;
    localparam int STAT_FCON_BIT  = 5;
    localparam int STAT_DIODE3_OPEN_FLAG_BIT = 3;
    localparam int STAT_DIODE2_OPEN_FLAG_BIT = 2;
    localparam int STAT_DIODE1_OPEN_FLAG_BIT = 1;
    // fraction field positions
    localparam int FRAC1_LSB = 5;
    localparam int FRAC2_LSB = 5;
    localparam int FRAC3_LSB = 2;
    // reset values
    localparam logic [7:0] CONFIG_RST       = 8'h02;
    localparam logic [2:0] RATE_RST         = 3'h4;
    localparam logic [7:0] TEMP_RST         = 8'h00;
    localparam logic [2:0] FRAC_RST         = 3'h0;
    localparam logic [7:0] FAN_TARGET_RST   = 8'hff;
    localparam logic [7:0] FAN_MEASURED_RST = 8'hff;
    localparam logic [7:0] FAN_DRIVE_RST    = 8'h00;
    localparam logic [3:0] OFFSET_RST       = 4'h0;
    localparam logic [1:0] PPR_RST          = 2'h0;
    localparam logic       UNLOCK_RST       = 1'b0;
    // conversion timing
    localparam int unsigned CLK_FREQ_HZ            = 200_000_000;
    localparam int unsigned FASTEST_CONV_PERIOD_MS = 125;
    localparam int unsigned FASTEST_CONV_CYCLES    =
        CLK_FREQ_HZ / 1000 * FASTEST_CONV_PERIOD_MS;
    localparam logic [2:0]  RATE_CODE_MAX          = 3'h7;

    // tach pulses per revolution from its 2-bit code
    function automatic logic [4:0] pulses_per_rev(input logic [1:0] code);
        pulses_per_rev = 5'h02 << code;
    endfunction
endpackage
`default_nettype wire

// >>> design/fan_tach_meter.sv
// tachometer period counter on the 32.768 khz reference clock
`timescale 1ns/10ps
`default_nettype none
module fan_tach_meter (
    // link clock and reset
    input  wire logic      i_tach_clk,
    input  wire logic      i_rst_n,
    // fan tachometer pin
    input  wire logic      i_fan_tach,
    // crossing to the register clock
    tach_xfer_if.tach_side xfer
);
    logic [1:0] rst_sync_q;  // reset brought into this domain
    logic [2:0] tach_sync_q; // two sync stages plus edge history
    logic [1:0] ppr_s1_q;    // code, first stage
    logic [1:0] ppr_s2_q;    // code, second stage
    logic       ack_s1_q;    // ack, first stage
    logic       ack_s2_q;    // ack, second stage
    logic [4:0] pulse_cnt_q; // tach edges seen this revolution
    logic [7:0] ref_cnt_q;   // reference ticks this revolution
    logic [7:0] count_q;     // offered count
    logic       req_q;       // offer toggle
    logic       rst_l;
    logic       tach_rise;
    logic       rev_done;
    logic       publish;

    assign rst_l     = rst_sync_q[1];
    assign tach_rise = tach_sync_q[1] & ~tach_sync_q[2];
    assign rev_done  = tach_rise &&
        (pulse_cnt_q == thermal_fan_pkg::pulses_per_rev(ppr_s2_q) - 5'h01);
    // offer only when the previous word was taken
    assign publish   = (rev_done || ref_cnt_q == 8'hff) && (req_q == ack_s2_q);
    assign xfer.count = count_q;
    assign xfer.req   = req_q;

    // reset and input synchronisers
    always_ff @(posedge i_tach_clk) begin
        rst_sync_q  <= {rst_sync_q[0], i_rst_n};
        tach_sync_q <= {tach_sync_q[1:0], i_fan_tach};
        ppr_s1_q    <= xfer.ppr_code;
        ppr_s2_q    <= ppr_s1_q;
        ack_s1_q    <= xfer.ack;
        ack_s2_q    <= ack_s1_q;
    end

    // revolution counters, reference count saturating at full scale
    always_ff @(posedge i_tach_clk) begin
        if (!rst_l) begin
            pulse_cnt_q <= 5'h00;
            ref_cnt_q   <= 8'h00;
        end else if (rev_done) begin
            pulse_cnt_q <= 5'h00;
            ref_cnt_q   <= 8'h00;
        end else begin
            if (tach_rise) begin
                pulse_cnt_q <= pulse_cnt_q + 5'h01;
            end
            if (ref_cnt_q != 8'hff) begin
                ref_cnt_q <= ref_cnt_q + 8'h01;
            end
        end
    end

    // offered word and its toggle
    always_ff @(posedge i_tach_clk) begin
        if (!rst_l) begin
            count_q <= thermal_fan_pkg::FAN_MEASURED_RST;
            req_q   <= 1'b0;
        end else if (publish) begin
            count_q <= ref_cnt_q;
            req_q   <= ~req_q;
        end
    end
endmodule
`default_nettype wire

// >>> design/tach_word_rx.sv
// register-clock receiver of the measured fan count
`timescale 1ns/10ps
`default_nettype none
module tach_word_rx (
    // clock and reset
    input  wire logic    i_clk,
    input  wire logic    i_rst_n,
    // crossing from the link clock
    tach_xfer_if.sys_side xfer,
    // received count
    output logic [7:0]   o_count
);
    logic [2:0] req_sync_q; // two stages plus edge history
    logic       ack_q;      // returned toggle

    assign xfer.ack = ack_q;

    // sync the toggle, take the word on its edge
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            req_sync_q <= 3'h0;
            ack_q      <= 1'b0;
            o_count    <= thermal_fan_pkg::FAN_MEASURED_RST;
        end else begin
            req_sync_q <= {req_sync_q[1:0], xfer.req};
            ack_q      <= req_sync_q[1];
            if (req_sync_q[1] ^ req_sync_q[2]) begin
                o_count <= xfer.count;
            end
        end
    end
endmodule
`default_nettype wire

// >>> design/thermal_fan_regs.sv
// command-addressed register bank of the thermometer and fan controller
`timescale 1ns/10ps
`default_nettype none
module thermal_fan_regs #(
    parameter int unsigned CONV_BASE_CYCLES = thermal_fan_pkg::FASTEST_CONV_CYCLES
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // tach reference clock and fan pin
    input  wire logic       i_tach_clk,
    input  wire logic       i_fan_tach,
    // command port from the serial engine
    input  wire logic [7:0] i_cmd,
    input  wire logic       i_wr_stb,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_rd_stb,
    output logic [7:0]      o_rdata,
    output logic            o_rd_valid,
    // converter side
    input  wire logic       i_conv_done,
    input  wire logic [7:0] i_temp1_high,
    input  wire logic [7:0] i_temp2_high,
    input  wire logic [7:0] i_temp3_high,
    input  wire logic [2:0] i_temp1_frac,
    input  wire logic [2:0] i_temp2_frac,
    input  wire logic [2:0] i_temp3_frac,
    input  wire logic [2:0] i_diode_open,
    input  wire logic [2:0] i_shutdown,
    output logic            o_conv_start,
    output logic [3:0]      o_offset1,
    output logic [3:0]      o_offset2,
    output logic [3:0]      o_offset3,
    // fan control loop side
    input  wire logic       i_fan_fail,
    input  wire logic       i_fan_out_of_ctrl,
    output logic            o_fan_loop_closed,
    output logic [7:0]      o_fan_target,
    output logic [7:0]      o_fan_drive,
    // alert pin
    output logic            o_alert_n
);
    logic [7:0]  temp1_q;      // channel 1 integer byte
    logic [7:0]  temp2_q;      // channel 2 integer byte
    logic [7:0]  temp3_q;      // channel 3 integer byte
    logic [2:0]  frac1_q;      // channel 1 eighths
    logic [2:0]  frac2_q;      // channel 2 eighths
    logic [2:0]  frac3_q;      // channel 3 eighths
    logic [2:0]  shutdown_q;   // per-channel shutdown
    logic        fail_q;       // sticky fan failure
    logic        fcon_q;       // sticky fan out of control
    logic        diode2_open_flag_q;      // sticky diode 2 open
    logic        diode3_open_flag_q;      // sticky diode 3 open
    logic        diode1_open_flag_q;      // live diode 1 open
    logic [7:0]  cfg_q;        // configuration byte
    logic [2:0]  rate_q;       // conversion rate code
    logic [7:0]  target_q;     // closed-loop target count
    logic [7:0]  drive_q;      // open-loop drive code
    logic [3:0]  offset1_q;    // channel 1 offset
    logic [3:0]  offset2_q;    // channel 2 offset
    logic [3:0]  offset3_q;    // channel 3 offset
    logic [1:0]  ppr_q;        // tach pulses per revolution code
    logic        unlock_q;     // write enable
    logic        busy_q;       // conversion in flight
    logic [31:0] timer_q;      // cycles since last start
    logic [7:0]  measured;     // count from the tach domain
    logic [7:0]  status;       // assembled status byte
    logic [7:0]  rd_mux;       // read data selection
    logic [31:0] period;       // cycles between periodic starts
    logic        wr_ok;        // write accepted
    logic        rd_status;    // status byte being read
    logic        single_conversion_trigger_req;  // accepted one-shot
    logic        start_now;    // conversion begins this cycle
    logic        fail_cond;    // gated fan failure
    logic        fcon_cond;    // gated out-of-control

    tach_xfer_if xfer ();

    // link-clock side of the fan count
    fan_tach_meter u_meter (
        .i_tach_clk (i_tach_clk),
        .i_rst_n    (i_rst_n),
        .i_fan_tach (i_fan_tach),
        .xfer       (xfer.tach_side)
    );

    // register-clock side of the fan count
    tach_word_rx u_rx (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .xfer    (xfer.sys_side),
        .o_count (measured)
    );

    assign xfer.ppr_code = ppr_q;

    assign o_fan_target      = target_q;
    assign o_fan_drive       = drive_q;
    assign o_offset1         = offset1_q;
    assign o_offset2         = offset2_q;
    assign o_offset3         = offset3_q;
    assign o_fan_loop_closed = cfg_q[thermal_fan_pkg::CFG_LOOP_BIT];

    assign wr_ok = i_wr_stb && (unlock_q || i_cmd == thermal_fan_pkg::CMD_UNLOCK);
    assign rd_status   = i_rd_stb && i_cmd == thermal_fan_pkg::CMD_FAULT_FLAGS;
    assign single_conversion_trigger_req = wr_ok && i_cmd == thermal_fan_pkg::CMD_SINGLE_CONVERSION_TRIGGER;
    assign fail_cond = i_fan_fail & cfg_q[thermal_fan_pkg::CFG_FAIL_DET_BIT];
    assign fcon_cond = i_fan_out_of_ctrl & cfg_q[thermal_fan_pkg::CFG_FCON_DET_BIT];

    assign period    = CONV_BASE_CYCLES << (thermal_fan_pkg::RATE_CODE_MAX - rate_q);
    // start on one-shot or period, never while busy
    assign start_now = !busy_q && (single_conversion_trigger_req || timer_q >= period - 32'h1);

    // latch readings when a conversion ends
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            temp1_q <= thermal_fan_pkg::TEMP_RST;
            temp2_q <= thermal_fan_pkg::TEMP_RST;
            temp3_q <= thermal_fan_pkg::TEMP_RST;
            frac1_q <= thermal_fan_pkg::FRAC_RST;
            frac2_q <= thermal_fan_pkg::FRAC_RST;
            frac3_q <= thermal_fan_pkg::FRAC_RST;
        end else if (i_conv_done) begin
            temp1_q <= i_temp1_high;
            temp2_q <= i_temp2_high;
            temp3_q <= i_temp3_high;
            frac1_q <= i_temp1_frac;
            frac2_q <= i_temp2_frac;
            frac3_q <= i_temp3_frac;
        end
    end

    // shutdown and diode 1 shown live
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            shutdown_q <= 3'h0;
            diode1_open_flag_q    <= 1'b0;
        end else begin
            shutdown_q <= i_shutdown;
            diode1_open_flag_q    <= i_diode_open[0];
        end
    end

    // sticky flags, a new event beats the read clear
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            fail_q  <= 1'b0;
            fcon_q  <= 1'b0;
            diode2_open_flag_q <= 1'b0;
            diode3_open_flag_q <= 1'b0;
        end else begin
            fail_q  <= fail_cond | (fail_q & ~rd_status);
            fcon_q  <= fcon_cond | (fcon_q & ~rd_status);
            diode2_open_flag_q <= i_diode_open[1] | (diode2_open_flag_q & ~rd_status);
            diode3_open_flag_q <= i_diode_open[2] | (diode3_open_flag_q & ~rd_status);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cfg_q <= thermal_fan_pkg::CONFIG_RST;
        end else if (wr_ok && i_cmd == thermal_fan_pkg::CMD_CONFIG_WR) begin
            cfg_q <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rate_q <= thermal_fan_pkg::RATE_RST;
        end else if (wr_ok && i_cmd == thermal_fan_pkg::CMD_RATE_WR) begin
            rate_q <= i_wdata[2:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            target_q  <= thermal_fan_pkg::FAN_TARGET_RST;
            drive_q   <= thermal_fan_pkg::FAN_DRIVE_RST;
            offset1_q <= thermal_fan_pkg::OFFSET_RST;
            offset2_q <= thermal_fan_pkg::OFFSET_RST;
            offset3_q <= thermal_fan_pkg::OFFSET_RST;
            ppr_q     <= thermal_fan_pkg::PPR_RST;
            unlock_q  <= thermal_fan_pkg::UNLOCK_RST;
        end else if (wr_ok) begin
            case (i_cmd)
                thermal_fan_pkg::CMD_FAN_TARGET: target_q  <= i_wdata;
                thermal_fan_pkg::CMD_FAN_DRIVE:  drive_q   <= i_wdata;
                thermal_fan_pkg::CMD_OFFSET1:    offset1_q <= i_wdata[3:0];
                thermal_fan_pkg::CMD_OFFSET2:    offset2_q <= i_wdata[3:0];
                thermal_fan_pkg::CMD_OFFSET3:    offset3_q <= i_wdata[3:0];
                thermal_fan_pkg::CMD_TACH_PPR:   ppr_q     <= i_wdata[1:0];
                thermal_fan_pkg::CMD_UNLOCK:
                    unlock_q <= i_wdata[thermal_fan_pkg::UNLOCK_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            busy_q       <= 1'b0;
            timer_q      <= 32'h0;
            o_conv_start <= 1'b0;
        end else begin
            o_conv_start <= start_now;
            if (start_now) begin
                busy_q  <= 1'b1;
                timer_q <= 32'h0;
            end else begin
                if (i_conv_done) begin
                    busy_q <= 1'b0;
                end
                if (timer_q != 32'hffffffff) begin
                    timer_q <= timer_q + 32'h1;
                end
            end
        end
    end

    // status byte assembly, reserved bits zero
    always_comb begin
        status = 8'h00;
        status[thermal_fan_pkg::STAT_BUSY_BIT]  = busy_q;
        status[thermal_fan_pkg::STAT_FAIL_BIT]  = fail_q;
        status[thermal_fan_pkg::STAT_FCON_BIT]  = fcon_q;
        status[thermal_fan_pkg::STAT_DIODE3_OPEN_FLAG_BIT] = diode3_open_flag_q;
        status[thermal_fan_pkg::STAT_DIODE2_OPEN_FLAG_BIT] = diode2_open_flag_q;
        status[thermal_fan_pkg::STAT_DIODE1_OPEN_FLAG_BIT] = diode1_open_flag_q;
    end

    // read selection, unmapped codes read zero
    always_comb begin
        rd_mux = 8'h00;
        case (i_cmd)
            thermal_fan_pkg::CMD_REMOTE2_HIGH:  rd_mux = temp2_q;
            thermal_fan_pkg::CMD_REMOTE1_HIGH:  rd_mux = temp1_q;
            thermal_fan_pkg::CMD_FAULT_FLAGS:   rd_mux = status;
            thermal_fan_pkg::CMD_CONFIG_RD:     rd_mux = cfg_q;
            thermal_fan_pkg::CMD_RATE_RD:       rd_mux = {5'h00, rate_q};
            thermal_fan_pkg::CMD_REMOTE3_HIGH:  rd_mux = temp3_q;
            thermal_fan_pkg::CMD_REMOTE1_FRAC:
                rd_mux[thermal_fan_pkg::FRAC1_LSB +: 3] = frac1_q;
            thermal_fan_pkg::CMD_REMOTE23_FRAC: begin
                rd_mux[thermal_fan_pkg::FRAC2_LSB +: 3] = frac2_q;
                rd_mux[thermal_fan_pkg::FRAC3_LSB +: 3] = frac3_q;
            end
            thermal_fan_pkg::CMD_SHUTDOWN:      rd_mux = {5'h00, shutdown_q};
            thermal_fan_pkg::CMD_FAN_TARGET:    rd_mux = target_q;
            thermal_fan_pkg::CMD_FAN_MEASURED:  rd_mux = measured;
            thermal_fan_pkg::CMD_FAN_DRIVE:     rd_mux = drive_q;
            thermal_fan_pkg::CMD_OFFSET1:       rd_mux = {4'h0, offset1_q};
            thermal_fan_pkg::CMD_OFFSET2:       rd_mux = {4'h0, offset2_q};
            thermal_fan_pkg::CMD_OFFSET3:       rd_mux = {4'h0, offset3_q};
            thermal_fan_pkg::CMD_TACH_PPR:      rd_mux = {6'h00, ppr_q};
            thermal_fan_pkg::CMD_UNLOCK:        rd_mux = {7'h00, unlock_q};
            default:                            rd_mux = 8'h00;
        endcase
    end

    // read answer one cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata    <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_stb;
            if (i_rd_stb) begin
                o_rdata <= rd_mux;
            end
        end
    end

    // alert from the sticky flags and live diode 1 unless masked
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_alert_n <= 1'b1;
        end else begin
            o_alert_n <= ~(|{fail_q, fcon_q, diode3_open_flag_q, diode2_open_flag_q, diode1_open_flag_q}
                           & ~cfg_q[thermal_fan_pkg::CFG_ALERT_MASK_BIT]);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_single_conversion_trigger_taken;
        single_conversion_trigger_req && !busy_q;
    endsequence
    sequence s_start_then_busy;
        o_conv_start && busy_q ##1 !o_conv_start;
    endsequence

    AST_SINGLE_CONVERSION_TRIGGER_STARTS: assert property (
        s_single_conversion_trigger_taken |=> s_start_then_busy)
        else $error("one-shot did not start a conversion");
    AST_BUSY_HOLDS: assert property (
        busy_q && !i_conv_done && !start_now |=> busy_q [*2] or ##1 $past(i_conv_done, 1))
        else $error("busy dropped before conversion done");
    AST_READ_CLEARS: assert property (
        rd_status && !fail_cond ##1 !fail_cond |-> !fail_q)
        else $error("status read did not clear fan failure");
    AST_FLAG_STICKY: assert property (
        diode3_open_flag_q && !rd_status |=> diode3_open_flag_q)
        else $error("diode 3 flag lost without a read");
    AST_FAIL_GATED: assert property (
        !cfg_q[thermal_fan_pkg::CFG_FAIL_DET_BIT] && !fail_q |=> !fail_q)
        else $error("fan failure flagged while detection off");
    AST_FCON_GATED: assert property (
        !cfg_q[thermal_fan_pkg::CFG_FCON_DET_BIT] && !fcon_q |=> !fcon_q)
        else $error("out of control flagged while detection off");
    AST_ALERT_MASKED: assert property (
        cfg_q[thermal_fan_pkg::CFG_ALERT_MASK_BIT] |=> o_alert_n)
        else $error("alert asserted while masked");
    AST_WRITE_LOCKED: assert property (
        i_wr_stb && !unlock_q && i_cmd != thermal_fan_pkg::CMD_UNLOCK
        |=> $stable(cfg_q) && $stable(target_q) && $stable(drive_q))
        else $error("locked write changed a register");
    AST_TARGET_READ: assert property (
        i_rd_stb && i_cmd == thermal_fan_pkg::CMD_FAN_TARGET
        |=> o_rd_valid && o_rdata == $past(target_q))
        else $error("target count read back wrong");
    AST_FRAC23_PACK: assert property (
        i_rd_stb && i_cmd == thermal_fan_pkg::CMD_REMOTE23_FRAC
        |=> o_rdata == {$past(frac2_q), $past(frac3_q), 2'h0})
        else $error("fraction byte packed wrong");
endmodule
`default_nettype wire

// >>> sim/conv_model.sv
// converter stand-in that finishes each conversion after a fixed delay
`timescale 1ns/10ps
`default_nettype none
module conv_model (
    // clock and conversion start
    input  wire logic i_clk,
    input  wire logic i_start,
    // completion pulse
    output logic      o_done
);
    int cnt; // cycles left in conversion
    always_ff @(posedge i_clk) begin
        o_done <= (cnt == 1);
        cnt <= i_start ? 20 : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule
`default_nettype wire

// >>> sim/test_thermal_fan_regs.sv
// self-checking bench for the thermal and fan register bank
`timescale 1ns/10ps
`default_nettype none
module test_thermal_fan_regs;
    logic       clk = 1'b0, tclk = 1'b0, rst_n = 1'b0, tach = 1'b0; // clocks, reset, fan pin
    logic       wr = 1'b0, rd = 1'b0, fail = 1'b0, fcon = 1'b0, rv, start, done, loop, alert_n;
    logic [7:0] cmd = 8'h00, wdata = 8'h00, rdata, tgt, drv;  // command port
    logic [7:0] t1 = 8'h3c, t2 = 8'h11, t3 = 8'h22;           // converter readings
    logic [2:0] f1 = 3'h6, f2 = 3'h5, f3 = 3'h5, sd = 3'h5, dopen = 3'h0;
    logic [3:0] of1, of2, of3;                                // offsets out
    int         err_count = 0, n_compared = 0, cyc = 0;
    // reset values, then written values, then converted values
    logic [15:0] rst_tab [9] = '{16'h0302, 16'h0404, 16'h10ff, 16'h11ff, 16'h1200,
                                 16'h2000, 16'h0000, 16'h1900, 16'h0900};
    logic [31:0] wr_tab [6] = '{32'h12a512a5, 32'h103c103c, 32'h16ff160f,
                                32'h19ff1903, 32'h0aff0407, 32'h09000300};
    logic [15:0] cv_tab [7] = '{16'h013c, 16'h0011, 16'h0522, 16'h06c0,
                                16'h07b4, 16'h0805, 16'h0200};
    thermal_fan_regs #(.CONV_BASE_CYCLES(100000)) DUT (
        .i_clk(clk), .i_rst_n(rst_n), .i_tach_clk(tclk), .i_fan_tach(tach),
        .i_cmd(cmd), .i_wr_stb(wr), .i_wdata(wdata), .i_rd_stb(rd),
        .o_rdata(rdata), .o_rd_valid(rv), .i_conv_done(done),
        .i_temp1_high(t1), .i_temp2_high(t2), .i_temp3_high(t3),
        .i_temp1_frac(f1), .i_temp2_frac(f2), .i_temp3_frac(f3),
        .i_diode_open(dopen), .i_shutdown(sd), .o_conv_start(start),
        .o_offset1(of1), .o_offset2(of2), .o_offset3(of3),
        .i_fan_fail(fail), .i_fan_out_of_ctrl(fcon), .o_fan_loop_closed(loop),
        .o_fan_target(tgt), .o_fan_drive(drv), .o_alert_n(alert_n));
    conv_model conv (.i_clk(clk), .i_start(start), .o_done(done));
    initial forever #2.5 clk = ~clk;
    initial begin
        #1.3;
        forever #3 tclk = ~tclk;
    end
    always #400 tach = ~tach;
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] c, input logic [7:0] d);
        @(negedge clk);
        {cmd, wdata, wr} = {c, d, 1'b1};
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] c, input logic [7:0] e);
        @(negedge clk);
        {cmd, rd} = {c, 1'b1};
        @(negedge clk);
        rd = 1'b0;
        chk("rd_valid", 8'h01, {7'h00, rv});
        chk("rdata", e, rdata);
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // cycle ceiling against hangs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        foreach (rst_tab[i]) rd_reg(rst_tab[i][15:8], rst_tab[i][7:0]);
        chk("loop", 8'h01, {7'h00, loop});
        wr_reg(8'h12, 8'h5a);
        rd_reg(8'h12, 8'h00);
        wr_reg(8'h20, 8'h01);
        foreach (wr_tab[i]) begin
            wr_reg(wr_tab[i][31:24], wr_tab[i][23:16]);
            rd_reg(wr_tab[i][15:8], wr_tab[i][7:0]);
        end
        chk("loop", 8'h00, {7'h00, loop});
        chk("fan_target", 8'h3c, tgt);
        chk("fan_drive", 8'ha5, drv);
        chk("offset1", 8'h0f, {4'h0, of1});
        chk("offset2_3", 8'h00, {of2, of3});
        {fail, fcon} = 2'b11;
        repeat (2) @(negedge clk);
        fail = 1'b0;
        rd_reg(8'h02, 8'h00);
        wr_reg(8'h09, 8'h30);
        {fail, fcon, dopen} = {2'b11, 3'h6};
        @(negedge clk);
        {fail, dopen} = 4'h0;
        repeat (2) @(negedge clk);
        chk("alert_n", 8'h00, {7'h00, alert_n});
        wr_reg(8'h09, 8'hb0);
        repeat (2) @(negedge clk);
        chk("alert_n", 8'h01, {7'h00, alert_n});
        rd_reg(8'h02, 8'h6c);
        fcon = 1'b0;
        rd_reg(8'h02, 8'h20);
        wr_reg(8'h0f, 8'h00);
        chk("conv_start", 8'h01, {7'h00, start});
        rd_reg(8'h02, 8'h80);
        repeat (30) @(negedge clk);
        foreach (cv_tab[i]) rd_reg(cv_tab[i][15:8], cv_tab[i][7:0]);
        wrap_up();
    end
endmodule
`default_nettype wire
